// ===== hw/servo_rf_pkg.sv
/*
  Constants, field layout and types for the servo and RF control word bank.
  Assumes a 32-bit AXI4-Lite register port; control words sit in the low half.
*/
package servo_rf_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [3:0]  RF_IDX        = 4'h8;
  localparam logic [3:0]  RADIAL_IDX    = 4'hb;
  localparam logic [3:0]  CENTRAL_IDX   = 4'hc;
  localparam logic [3:0]  STATUS_IDX    = 4'h1;
  localparam int          IDX_LO        = 2;
  localparam int          IDX_HI        = 5;

  // Control word layout
  localparam int          SEL_HI        = 15;
  localparam int          SEL_LO        = 12;
  localparam int          BODY_W        = 12;
  localparam int          NUM_CHAN      = 4;
  localparam int          CHAN_STRIDE   = 2;
  localparam int          BLOCK_OFS     = 1;
  localparam int          FLIP_OFS      = 0;
  localparam int          RF_USED_W     = 8;
  localparam int          LF_HI         = 11;
  localparam int          LF_LO         = 10;
  localparam int          SCALE_POS     = 9;
  localparam int          FTC_POS       = 8;
  localparam int          UPPER_HI      = 7;
  localparam int          UPPER_LO      = 4;
  localparam int          LOWER_HI      = 3;
  localparam int          LOWER_LO      = 0;
  localparam int          DPD_POS       = 11;
  localparam int          TST_HI        = 10;
  localparam int          TST_LO        = 8;

  localparam logic [11:0] BODY_RST      = 12'h000;
  localparam logic [7:0]  CNT_RST       = 8'h00;

  // Offset magnitudes in units of one third of a millivolt
  localparam int          MAG_W         = 8;
  localparam int          CODE_W        = 4;
  localparam logic [7:0]  CODE_STEP     = 8'h04;
  localparam logic [7:0]  LF_STEP       = 8'h0f;
  localparam logic [7:0]  TRIPLE_MULT   = 8'h03;

  localparam logic [10:0] FTC_NARROW_KHZ = 11'd600;
  localparam logic [10:0] FTC_WIDE_KHZ   = 11'd1200;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  typedef enum logic [2:0] {
    ST_NORMAL = 3'b000,
    ST_DAC    = 3'b001,
    ST_SUM    = 3'b011,
    ST_CHAN_A = 3'b100,
    ST_CHAN_B = 3'b101,
    ST_CHAN_C = 3'b110,
    ST_CHAN_D = 3'b111
  } servo_test_type;

endpackage

// ===== hw/offset_scaler.sv
/*
  Registered scaler turning an offset code into a magnitude in third-millivolts.
  Assumes the caller supplies the step per code count and the range select.
*/
`timescale 1ns/100ps
module offset_scaler #(
  parameter int         CODE_W = 4,
  parameter int         MAG_W  = 8,
  parameter logic [7:0] STEP   = 8'h04
) (
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              ce_in,
  input  wire logic [CODE_W-1:0] code_in,
  input  wire logic              triple_in,
  output logic      [MAG_W-1:0]  mag_out
);
  import servo_rf_pkg::*;

  logic [MAG_W-1:0] base;
  logic [MAG_W-1:0] mag_d;

  // Linear code map, zero code gives zero offset
  always_comb begin
    base  = MAG_W'(code_in) * MAG_W'(STEP);
    mag_d = triple_in ? MAG_W'(base * MAG_W'(TRIPLE_MULT)) : base;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mag_out <= '0;
    end else if (ce_in) begin
      mag_out <= mag_d;
    end
  end

endmodule

// ===== hw/word_gate.sv
/*
  Decides whether a bus write carries a complete control word for a known register.
  Assumes an aligned byte address whose word index selects the register.
*/
`timescale 1ns/100ps
module word_gate #(
  parameter int ADDR_W = 8
) (
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [3:0]        nibble_in,
  input  wire logic [1:0]        strb_in,
  output logic                   hit_rf_out,
  output logic                   hit_radial_out,
  output logic                   hit_central_out,
  output logic      [1:0]        resp_out
);
  import servo_rf_pkg::*;

  logic [3:0] idx;
  logic       mapped;
  logic       whole;

  always_comb begin
    idx    = addr_in[IDX_HI:IDX_LO];
    mapped = (addr_in[1:0] == 2'h0) && (addr_in[ADDR_W-1:IDX_HI+1] == '0) &&
             ((idx == RF_IDX) || (idx == RADIAL_IDX) || (idx == CENTRAL_IDX));
    // Word counts only when both low lanes arrive and the selector matches
    whole  = (strb_in == 2'h3) && (nibble_in == idx);
    hit_rf_out      = mapped && whole && (idx == RF_IDX);
    hit_radial_out  = mapped && whole && (idx == RADIAL_IDX);
    hit_central_out = mapped && whole && (idx == CENTRAL_IDX);
    if (!mapped) begin
      resp_out = (addr_in == {{(ADDR_W-6){1'b0}}, STATUS_IDX, 2'h0}) ? RESP_SLVERR : RESP_DECERR;
    end else if (!whole) begin
      resp_out = RESP_SLVERR;
    end else begin
      resp_out = RESP_OKAY;
    end
  end

endmodule

// ===== hw/servo_rf_control_registers.sv
/*
  Control word bank for the RF channel switches, radial and central servo offsets.
  Assumes an AXI4-Lite master with 32-bit data on MCLK_IN; SRST_IN is synchronous.
*/
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
module servo_rf_control_registers #(
  parameter int ADDR_W = 8
) (
  input  wire logic                   MCLK_IN,
  input  wire logic                   SRST_IN,
  input  wire logic                   CE_IN,
  input  wire logic [ADDR_W-1:0]      S_AXI_AWADDR_IN,
  input  wire logic                   S_AXI_AWVALID_IN,
  output logic                        S_AXI_AWREADY_OUT,
  input  wire logic [31:0]            S_AXI_WDATA_IN,
  input  wire logic [3:0]             S_AXI_WSTRB_IN,
  input  wire logic                   S_AXI_WVALID_IN,
  output logic                        S_AXI_WREADY_OUT,
  output logic      [1:0]             S_AXI_BRESP_OUT,
  output logic                        S_AXI_BVALID_OUT,
  input  wire logic                   S_AXI_BREADY_IN,
  input  wire logic [ADDR_W-1:0]      S_AXI_ARADDR_IN,
  input  wire logic                   S_AXI_ARVALID_IN,
  output logic                        S_AXI_ARREADY_OUT,
  output logic      [31:0]            S_AXI_RDATA_OUT,
  output logic      [1:0]             S_AXI_RRESP_OUT,
  output logic                        S_AXI_RVALID_OUT,
  input  wire logic                   S_AXI_RREADY_IN,
  output logic      [3:0]             CHAN_BLOCK_OUT,
  output logic      [3:0]             CHAN_FLIP_OUT,
  output logic      [1:0]             LOWFREQ_PATH_OFFSET_OUT,
  output logic                        OFFSET_SCALE_SEL_OUT,
  output logic                        FTC_BW_SEL_OUT,
  output logic      [10:0]            FTC_BW_KHZ_OUT,
  output logic      [3:0]             RADIAL_E_OFFSET_OUT,
  output logic      [3:0]             RADIAL_F_OFFSET_OUT,
  output logic                        DPD_RF_TEST_BIT_OUT,
  output servo_rf_pkg::servo_test_type SERVO_TEST_SELECT_OUT,
  output logic      [3:0]             CENTRAL_A_OFFSET_OUT,
  output logic      [3:0]             CENTRAL_B_OFFSET_OUT,
  output logic      [7:0]             LOWFREQ_MAG_OUT,
  output logic      [7:0]             RADIAL_E_MAG_OUT,
  output logic      [7:0]             RADIAL_F_MAG_OUT,
  output logic      [7:0]             CENTRAL_A_MAG_OUT,
  output logic      [7:0]             CENTRAL_B_MAG_OUT,
  output logic                        RF_OUT_FROM_DPD_OUT,
  output logic                        CENTRAL_SRC_DAC_OUT,
  output logic                        CENTRAL_SRC_SUM_OUT,
  output logic      [3:0]             CENTRAL_SRC_CHAN_OUT
);
  import servo_rf_pkg::*;

  logic [ADDR_W-1:0] awaddr_q;
  logic              aw_have_q;
  logic [15:0]       wdata_q;
  logic [1:0]        wstrb_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic [11:0]       rf_q;
  logic [11:0]       radial_q;
  logic [11:0]       central_q;
  logic [7:0]        accept_cnt_q;
  logic [7:0]        reject_cnt_q;
  logic [10:0]       ftc_khz_q;
  logic              src_dac_q;
  logic              src_sum_q;
  logic [3:0]        src_chan_q;
  logic              aw_fire;
  logic              w_fire;
  logic              ar_fire;
  logic              commit;
  logic              hit_rf;
  logic              hit_radial;
  logic              hit_central;
  logic [1:0]        gate_resp;
  logic [3:0]        rd_idx;
  logic              rd_aligned;
  logic [3:0]        code_arr [5];
  logic [7:0]        mag_arr  [5];

  // Ready and valid are gated by the enable so a frozen slave never completes a beat
  assign S_AXI_AWREADY_OUT = CE_IN && !aw_have_q && !bvalid_q;
  assign S_AXI_WREADY_OUT  = CE_IN && !w_have_q && !bvalid_q;
  assign S_AXI_ARREADY_OUT = CE_IN && !rvalid_q;
  assign S_AXI_BVALID_OUT  = CE_IN && bvalid_q;
  assign S_AXI_RVALID_OUT  = CE_IN && rvalid_q;
  assign S_AXI_BRESP_OUT   = bresp_q;
  assign S_AXI_RRESP_OUT   = rresp_q;
  assign S_AXI_RDATA_OUT   = rdata_q;
  assign aw_fire = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
  assign w_fire  = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  assign ar_fire = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  assign commit  = CE_IN && aw_have_q && w_have_q && !bvalid_q;

  word_gate #(
    .ADDR_W          (ADDR_W)
  ) u_gate (
    .addr_in         (awaddr_q),
    .nibble_in       (wdata_q[SEL_HI:SEL_LO]),
    .strb_in         (wstrb_q),
    .hit_rf_out      (hit_rf),
    .hit_radial_out  (hit_radial),
    .hit_central_out (hit_central),
    .resp_out        (gate_resp)
  );

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (aw_fire) begin
      aw_have_q <= 1'b1;
      awaddr_q  <= S_AXI_AWADDR_IN;
    end else if (commit) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      w_have_q <= 1'b0;
      wdata_q  <= 16'h0000;
      wstrb_q  <= 2'h0;
    end else if (w_fire) begin
      w_have_q <= 1'b1;
      wdata_q  <= S_AXI_WDATA_IN[15:0];
      wstrb_q  <= S_AXI_WSTRB_IN[1:0];
    end else if (commit) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (commit) begin
      bvalid_q <= 1'b1;
      bresp_q  <= gate_resp;
    end else if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
      bvalid_q <= 1'b0;
    end
  end

  // Only a whole word addressed by its own selector lands
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      rf_q      <= BODY_RST;
      radial_q  <= BODY_RST;
      central_q <= BODY_RST;
    end else if (commit) begin
      if (hit_rf) begin
        rf_q <= {{(BODY_W-RF_USED_W){1'b0}}, wdata_q[RF_USED_W-1:0]};
      end
      if (hit_radial) begin
        radial_q <= wdata_q[BODY_W-1:0];
      end
      if (hit_central) begin
        central_q <= wdata_q[BODY_W-1:0];
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      accept_cnt_q <= CNT_RST;
      reject_cnt_q <= CNT_RST;
    end else if (commit) begin
      if (gate_resp == RESP_OKAY) begin
        accept_cnt_q <= accept_cnt_q + 8'h01;
      end else begin
        reject_cnt_q <= reject_cnt_q + 8'h01;
      end
    end
  end

  // Read side: stored words with their selector, or the write counters
  assign rd_idx     = S_AXI_ARADDR_IN[IDX_HI:IDX_LO];
  assign rd_aligned = (S_AXI_ARADDR_IN[1:0] == 2'h0) && (S_AXI_ARADDR_IN[ADDR_W-1:IDX_HI+1] == '0);

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      if (rd_aligned && rd_idx == RF_IDX) begin
        rdata_q <= {16'h0000, RF_IDX, rf_q};
      end else if (rd_aligned && rd_idx == RADIAL_IDX) begin
        rdata_q <= {16'h0000, RADIAL_IDX, radial_q};
      end else if (rd_aligned && rd_idx == CENTRAL_IDX) begin
        rdata_q <= {16'h0000, CENTRAL_IDX, central_q};
      end else if (rd_aligned && rd_idx == STATUS_IDX) begin
        rdata_q <= {16'h0000, reject_cnt_q, accept_cnt_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_DECERR;
      end
    end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
      rvalid_q <= 1'b0;
    end
  end

  // Channel switch bits, one pair per photodiode channel, A at the bottom
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    assign CHAN_BLOCK_OUT[ch] = rf_q[CHAN_STRIDE*ch+BLOCK_OFS];
    assign CHAN_FLIP_OUT[ch]  = rf_q[CHAN_STRIDE*ch+FLIP_OFS];
  end

  assign LOWFREQ_PATH_OFFSET_OUT = radial_q[LF_HI:LF_LO];
  assign OFFSET_SCALE_SEL_OUT    = radial_q[SCALE_POS];
  assign FTC_BW_SEL_OUT          = radial_q[FTC_POS];
  assign RADIAL_E_OFFSET_OUT     = radial_q[UPPER_HI:UPPER_LO];
  assign RADIAL_F_OFFSET_OUT     = radial_q[LOWER_HI:LOWER_LO];
  assign DPD_RF_TEST_BIT_OUT     = central_q[DPD_POS];
  assign SERVO_TEST_SELECT_OUT   = servo_test_type'(central_q[TST_HI:TST_LO]);
  assign CENTRAL_A_OFFSET_OUT    = central_q[UPPER_HI:UPPER_LO];
  assign CENTRAL_B_OFFSET_OUT    = central_q[LOWER_HI:LOWER_LO];
  assign RF_OUT_FROM_DPD_OUT     = central_q[DPD_POS];

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      ftc_khz_q <= FTC_NARROW_KHZ;
    end else if (CE_IN) begin
      ftc_khz_q <= radial_q[FTC_POS] ? FTC_WIDE_KHZ : FTC_NARROW_KHZ;
    end
  end
  assign FTC_BW_KHZ_OUT = ftc_khz_q;

  // Unlisted code 010 falls back to normal routing rather than float
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      src_dac_q  <= 1'b0;
      src_sum_q  <= 1'b0;
      src_chan_q <= 4'h0;
    end else if (CE_IN) begin
      src_dac_q  <= 1'b0;
      src_sum_q  <= 1'b0;
      src_chan_q <= 4'h0;
      unique case (central_q[TST_HI:TST_LO])
        ST_NORMAL: src_chan_q <= 4'h0;
        ST_DAC:    src_dac_q  <= 1'b1;
        ST_SUM:    src_sum_q  <= 1'b1;
        ST_CHAN_A: src_chan_q <= 4'h1;
        ST_CHAN_B: src_chan_q <= 4'h2;
        ST_CHAN_C: src_chan_q <= 4'h4;
        ST_CHAN_D: src_chan_q <= 4'h8;
        default:   src_chan_q <= 4'h0;
      endcase
    end
  end
  assign CENTRAL_SRC_DAC_OUT  = src_dac_q;
  assign CENTRAL_SRC_SUM_OUT  = src_sum_q;
  assign CENTRAL_SRC_CHAN_OUT = src_chan_q;

  // Offset magnitudes: 0 E, 1 F, 2 central A, 3 central B, 4 low-frequency
  assign code_arr[0] = radial_q[UPPER_HI:UPPER_LO];
  assign code_arr[1] = radial_q[LOWER_HI:LOWER_LO];
  assign code_arr[2] = central_q[UPPER_HI:UPPER_LO];
  assign code_arr[3] = central_q[LOWER_HI:LOWER_LO];
  assign code_arr[4] = {2'h0, radial_q[LF_HI:LF_LO]};
  for (genvar k = 0; k < 5; k++) begin : g_mag
    offset_scaler #(
      .CODE_W    (CODE_W),
      .MAG_W     (MAG_W),
      .STEP      ((k == 4) ? LF_STEP : CODE_STEP)
    ) u_scale (
      .clk_in    (MCLK_IN),
      .srst_in   (SRST_IN),
      .ce_in     (CE_IN),
      .code_in   (code_arr[k]),
      .triple_in (radial_q[SCALE_POS]),
      .mag_out   (mag_arr[k])
    );
  end
  assign RADIAL_E_MAG_OUT  = mag_arr[0];
  assign RADIAL_F_MAG_OUT  = mag_arr[1];
  assign CENTRAL_A_MAG_OUT = mag_arr[2];
  assign CENTRAL_B_MAG_OUT = mag_arr[3];
  assign LOWFREQ_MAG_OUT   = mag_arr[4];

  property p_sel_gate;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      commit && wdata_q[SEL_HI:SEL_LO] != awaddr_q[IDX_HI:IDX_LO] |=> $stable({rf_q, radial_q, central_q});
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("Mismatched selector changed a register");
  property p_block_bits;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      commit && hit_rf |=> CHAN_BLOCK_OUT == {$past(wdata_q[7]), $past(wdata_q[5]), $past(wdata_q[3]),
                                             $past(wdata_q[1])};
  endproperty
  a_block_bits: assert property (p_block_bits) else $error("Mute bits not taken from the word");
  property p_flip_bits;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      commit && hit_rf |=> CHAN_FLIP_OUT == {$past(wdata_q[6]), $past(wdata_q[4]), $past(wdata_q[2]),
                                            $past(wdata_q[0])};
  endproperty
  a_flip_bits: assert property (p_flip_bits) else $error("Invert bits not taken from the word");
  property p_lf_top;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      CE_IN && radial_q[LF_HI:LF_LO] == 2'h3 |=> LOWFREQ_MAG_OUT == ($past(radial_q[SCALE_POS]) ? 8'd135 : 8'd45);
  endproperty
  a_lf_top: assert property (p_lf_top) else $error("Low-frequency offset top code wrong");
  property p_triple_e;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      CE_IN && radial_q[UPPER_HI:UPPER_LO] == 4'hf && radial_q[SCALE_POS] |=> RADIAL_E_MAG_OUT == 8'd180;
  endproperty
  a_triple_e: assert property (p_triple_e) else $error("Triple range E full scale wrong");
  property p_ftc;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      CE_IN ##1 CE_IN |-> FTC_BW_KHZ_OUT == ($past(radial_q[FTC_POS]) ? 11'd1200 : 11'd600);
  endproperty
  a_ftc: assert property (p_ftc) else $error("FTC bandwidth does not follow its bit");
  property p_radial_codes;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      commit && hit_radial |=> {RADIAL_E_OFFSET_OUT, RADIAL_F_OFFSET_OUT} == $past(wdata_q[7:0]);
  endproperty
  a_radial_codes: assert property (p_radial_codes) else $error("Radial codes not stored");
  property p_dpd_route;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      commit && hit_central |=> RF_OUT_FROM_DPD_OUT == $past(wdata_q[11]);
  endproperty
  a_dpd_route: assert property (p_dpd_route) else $error("DPD RF routing not updated");
  property p_sum_route;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      CE_IN && central_q[TST_HI:TST_LO] == 3'b011 |=>
        CENTRAL_SRC_SUM_OUT && CENTRAL_SRC_CHAN_OUT == 4'h0 && !CENTRAL_SRC_DAC_OUT;
  endproperty
  a_sum_route: assert property (p_sum_route) else $error("Sum routing wrong");
  property p_central_a;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      CE_IN && CENTRAL_A_OFFSET_OUT == 4'hf |=> CENTRAL_A_MAG_OUT == ($past(OFFSET_SCALE_SEL_OUT) ? 8'd180 : 8'd60);
  endproperty
  a_central_a: assert property (p_central_a) else $error("Central A full scale wrong");
  property p_reject_hold;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      commit && gate_resp != RESP_OKAY |=> $stable({rf_q, radial_q, central_q}) && S_AXI_BRESP_OUT != RESP_OKAY;
  endproperty
  a_reject_hold: assert property (p_reject_hold) else $error("Rejected word changed a register");
  property p_rf_unused;
    @(posedge MCLK_IN) disable iff (SRST_IN)
      commit && hit_rf |=> rf_q[11:8] == 4'h0;
  endproperty
  a_rf_unused: assert property (p_rf_unused) else $error("Unused channel bits stored");

endmodule

// ===== dv/servo_host_model.sv
/*
  Register bus host that stands in for the controller writing control words.
  Assumes one AXI4-Lite slave on clk_in; hang_out rises when a handshake stalls.
*/
`timescale 1ns/100ps
module servo_host_model (
  input  wire logic        clk_in,
  output logic      [7:0]  awaddr_out  = 8'h00,
  output logic             awvalid_out = 1'b0,
  input  wire logic        awready_in,
  output logic      [31:0] wdata_out   = 32'h0,
  output logic      [3:0]  wstrb_out   = 4'h0,
  output logic             wvalid_out  = 1'b0,
  input  wire logic        wready_in,
  input  wire logic [1:0]  bresp_in,
  input  wire logic        bvalid_in,
  output logic             bready_out  = 1'b0,
  output logic      [7:0]  araddr_out  = 8'h00,
  output logic             arvalid_out = 1'b0,
  input  wire logic        arready_in,
  input  wire logic [31:0] rdata_in,
  input  wire logic [1:0]  rresp_in,
  input  wire logic        rvalid_in,
  output logic             rready_out  = 1'b0,
  output logic             hang_out    = 1'b0
);
  // Ready sampled mid-cycle; it only moves after edges, so this is the edge value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= s;
    awvalid_out <= 1'b1;
    wvalid_out <= 1'b1;
    bready_out <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 40 && !tb; n++) begin
      @(negedge clk_in);
      ta = awvalid_out & awready_in;
      tw = wvalid_out & wready_in;
      tb = bvalid_in & bready_out;
      r = bresp_in;
      @(posedge clk_in);
      if (ta) awvalid_out <= 1'b0;
      if (tw) wvalid_out <= 1'b0;
      if (tb) bready_out <= 1'b0;
    end
    if (!tb) hang_out <= 1'b1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    rready_out <= 1'b1;
    tr = 1'b0;
    for (int n = 0; n < 40 && !tr; n++) begin
      @(negedge clk_in);
      ta = arvalid_out & arready_in;
      tr = rvalid_in & rready_out;
      d = rdata_in;
      r = rresp_in;
      @(posedge clk_in);
      if (ta) arvalid_out <= 1'b0;
      if (tr) rready_out <= 1'b0;
    end
    if (!tr) hang_out <= 1'b1;
  endtask
endmodule

// ===== dv/servo_rf_control_registers_test.sv
/*
  Self-checking bench for the servo and RF control word bank.
  Assumes servo_host_model drives the register bus; CE_IN high except in the freeze test.
*/
`timescale 1ns/100ps
module servo_rf_control_registers_test;
  import servo_rf_pkg::*;
  logic MCLK_IN = 1'b0, SRST_IN = 1'b1, CE_IN = 1'b1, hang;
  logic S_AXI_AWVALID_IN, S_AXI_AWREADY_OUT, S_AXI_WVALID_IN, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_BREADY_IN;
  logic S_AXI_ARVALID_IN, S_AXI_ARREADY_OUT, S_AXI_RVALID_OUT, S_AXI_RREADY_IN;
  logic OFFSET_SCALE_SEL_OUT, FTC_BW_SEL_OUT, DPD_RF_TEST_BIT_OUT, RF_OUT_FROM_DPD_OUT;
  logic CENTRAL_SRC_DAC_OUT, CENTRAL_SRC_SUM_OUT;
  logic [7:0] S_AXI_AWADDR_IN, S_AXI_ARADDR_IN, LOWFREQ_MAG_OUT, RADIAL_E_MAG_OUT, RADIAL_F_MAG_OUT;
  logic [7:0] CENTRAL_A_MAG_OUT, CENTRAL_B_MAG_OUT;
  logic [31:0] S_AXI_WDATA_IN, S_AXI_RDATA_OUT, d;
  logic [3:0] S_AXI_WSTRB_IN, CHAN_BLOCK_OUT, CHAN_FLIP_OUT, RADIAL_E_OFFSET_OUT, RADIAL_F_OFFSET_OUT;
  logic [3:0] CENTRAL_A_OFFSET_OUT, CENTRAL_B_OFFSET_OUT, CENTRAL_SRC_CHAN_OUT;
  logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, LOWFREQ_PATH_OFFSET_OUT, r;
  logic [10:0] FTC_BW_KHZ_OUT;
  servo_test_type SERVO_TEST_SELECT_OUT;
  int num_errors = 0, checks_done = 0;

  always #10 MCLK_IN = ~MCLK_IN;
  servo_rf_control_registers servo_rf_control_registers_i (.*);
  servo_host_model servo_host_model_i (.clk_in(MCLK_IN), .awaddr_out(S_AXI_AWADDR_IN),
    .awvalid_out(S_AXI_AWVALID_IN), .awready_in(S_AXI_AWREADY_OUT), .wdata_out(S_AXI_WDATA_IN),
    .wstrb_out(S_AXI_WSTRB_IN), .wvalid_out(S_AXI_WVALID_IN), .wready_in(S_AXI_WREADY_OUT),
    .bresp_in(S_AXI_BRESP_OUT), .bvalid_in(S_AXI_BVALID_OUT), .bready_out(S_AXI_BREADY_IN),
    .araddr_out(S_AXI_ARADDR_IN), .arvalid_out(S_AXI_ARVALID_IN), .arready_in(S_AXI_ARREADY_OUT),
    .rdata_in(S_AXI_RDATA_OUT), .rresp_in(S_AXI_RRESP_OUT), .rvalid_in(S_AXI_RVALID_OUT),
    .rready_out(S_AXI_RREADY_IN), .hang_out(hang));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Returns at the first negedge after the response, where derived outputs have landed
  task automatic wreg(input logic [7:0] a, input logic [15:0] w, input logic [3:0] s, input logic [1:0] e);
    servo_host_model_i.wr(a, {16'h0, w}, s, r);
    chk(r, e);
    @(negedge MCLK_IN);
  endtask

  task automatic t_chan;
    for (int b = 0; b < 8; b++) begin
      wreg(8'h20, 16'h8f00 | (16'h1 << b), 4'h3, RESP_OKAY);
      chk(CHAN_BLOCK_OUT, b[0] ? 4'h1 << b[2:1] : 4'h0);
      chk(CHAN_FLIP_OUT, b[0] ? 4'h0 : 4'h1 << b[2:1]);
    end
    servo_host_model_i.rd(8'h20, d, r);
    chk(d, 32'h8080);
    $display("channel test done");
  endtask

  task automatic t_radial;
    logic [1:0] lf;
    logic sc;
    for (int i = 0; i < 8; i++) begin
      lf = i[1:0];
      sc = i[2];
      wreg(8'h2c, {4'hb, lf, sc, lf[0], 4'hf, 2'b00, lf}, 4'hf, RESP_OKAY);
      chk({LOWFREQ_PATH_OFFSET_OUT, LOWFREQ_MAG_OUT}, {lf, 8'(32'(lf) * (sc ? 45 : 15))});
      chk(OFFSET_SCALE_SEL_OUT, sc);
      chk({FTC_BW_SEL_OUT, FTC_BW_KHZ_OUT}, {lf[0], lf[0] ? 11'd1200 : 11'd600});
      chk({RADIAL_E_OFFSET_OUT, RADIAL_E_MAG_OUT}, {4'hf, sc ? 8'd180 : 8'd60});
      chk({RADIAL_F_OFFSET_OUT, RADIAL_F_MAG_OUT}, {2'b00, lf, 8'(32'(lf) * (sc ? 12 : 4))});
    end
    $display("radial test done");
  endtask

  // Scale bit left in triple range by the radial test
  task automatic t_central;
    logic [2:0] c;
    logic [3:0] ch;
    logic [3:0] ca;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      ch = c[2] ? 4'h1 << c[1:0] : 4'h0;
      // Inverted code kept at four bits so the cast cannot widen the inversion
      ca = ~{1'b0, c};
      wreg(8'h30, {4'hc, c[0], c, ~{1'b0, c}, {1'b0, c}}, 4'hf, RESP_OKAY);
      chk({DPD_RF_TEST_BIT_OUT, SERVO_TEST_SELECT_OUT}, {c[0], c});
      chk(RF_OUT_FROM_DPD_OUT, c[0]);
      chk({CENTRAL_SRC_DAC_OUT, CENTRAL_SRC_SUM_OUT, CENTRAL_SRC_CHAN_OUT}, {c == 3'h1, c == 3'h3, ch});
      chk({CENTRAL_A_OFFSET_OUT, CENTRAL_B_OFFSET_OUT}, {~{1'b0, c}, 1'b0, c});
      chk({CENTRAL_A_MAG_OUT, CENTRAL_B_MAG_OUT}, {8'(32'(ca) * 12), 8'(32'(c) * 12)});
    end
    $display("central test done");
  endtask

  task automatic t_refuse;
    wreg(8'h20, 16'hb0ff, 4'hf, RESP_SLVERR);
    wreg(8'h20, 16'h80ff, 4'h1, RESP_SLVERR);
    wreg(8'h3c, 16'h80ff, 4'hf, RESP_DECERR);
    chk({CHAN_BLOCK_OUT, CHAN_FLIP_OUT}, 8'h80);
    servo_host_model_i.rd(8'h3c, d, r);
    chk({d[15:0], r}, {16'h0, RESP_DECERR});
    wreg(8'h04, 16'h1000, 4'hf, RESP_SLVERR);
    // 24 accepted words so far, 4 refused
    servo_host_model_i.rd(8'h04, d, r);
    chk({d[15:0], r}, {16'h0418, RESP_OKAY});
    $display("refusal test done");
  endtask

  task automatic t_freeze;
    @(posedge MCLK_IN);
    CE_IN <= 1'b0;
    @(negedge MCLK_IN);
    chk({S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_ARREADY_OUT, FTC_BW_KHZ_OUT}, {3'h0, 11'd1200});
    @(posedge MCLK_IN);
    CE_IN <= 1'b1;
    $display("freeze test done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge hang) begin
    num_errors++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge MCLK_IN);
    SRST_IN <= 1'b0;
    @(negedge MCLK_IN);
    chk({CHAN_BLOCK_OUT, FTC_BW_KHZ_OUT}, {4'h0, 11'd600});
    t_chan();
    t_radial();
    t_central();
    t_refuse();
    t_freeze();
    conclude();
  end
endmodule
